// *** afc_regs.sv ***
`timescale 1ns/1ps
`include "afc_defs.svh"

// Functional notes
// - chop register at 0x74, resets to 0x1
// - chop bit0: 1 disables, 0 enables chopping
// - chopping enabled doubles converter sample time
// - amp2 control at 0xA0, resets to 0x19
// - bit14 sink boost, read/write, resets 0
// - bits12:11 bias select, sources eight..eleven
// - bits10:8 transimpedance resistor code, resets 0
// - bits7:5 amplifier gain code, resets 0
// - bit3 filter capacitor bypass, resets 1
// - bit2 coupling: 0 DC, 1 AC
// - bit1 function: 0 gain, 1 transimpedance
module afc_regs (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // axi4-lite write address
  input  wire logic                   s_axi_awvalid_in,
  input  wire logic [`AFC_ADDR_W-1:0] s_axi_awaddr_in,
  output logic                        s_axi_awready_out,
  // axi4-lite write data
  input  wire logic                   s_axi_wvalid_in,
  input  wire logic [`AFC_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [`AFC_STRB_W-1:0] s_axi_wstrb_in,
  output logic                        s_axi_wready_out,
  // axi4-lite write response
  output logic                        s_axi_bvalid_out,
  output logic [1:0]                  s_axi_bresp_out,
  input  wire logic                   s_axi_bready_in,
  // axi4-lite read address
  input  wire logic                   s_axi_arvalid_in,
  input  wire logic [`AFC_ADDR_W-1:0] s_axi_araddr_in,
  output logic                        s_axi_arready_out,
  // axi4-lite read data
  output logic                        s_axi_rvalid_out,
  output logic [`AFC_DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  input  wire logic                   s_axi_rready_in,
  // amplifier one chop control
  output logic                        chop_disable_out,
  output logic [1:0]                  sample_time_mult_out,
  // amplifier two configuration
  output afc_pkg::afc_amp2_cfg_t      amp2_cfg_out,
  output logic [3:0]                  bias_source_onehot_out,
  output logic                        code_invalid_out
);
  // reset words and offsets as sized constants
  localparam logic [31:0] CHOP_RST = `AFC_CHOP_RESET;
  localparam logic [31:0] AMP2_RST = `AFC_AMP2_RESET;
  localparam logic [7:0]  CHOP_OFF = `AFC_CHOP_OFFSET;
  localparam logic [7:0]  AMP2_OFF = `AFC_AMP2_OFFSET;

  afc_pkg::afc_state_t st;
  afc_pkg::afc_state_t next_st;

  // field storage outputs
  logic       chop_q;
  logic       sink_q;
  logic       spare13_q;
  logic [1:0] bias_q;
  logic [2:0] res_q;
  logic [2:0] gain_q;
  logic       spare4_q;
  logic       cap_q;
  logic       coup_q;
  logic       func_q;
  logic       pd_q;

  // write decode
  logic       wr_fire;
  logic       wr_hit_chop;
  logic       wr_hit_amp2;
  logic       we_chop;
  logic       we_amp2_b0;
  logic       we_amp2_b1;
  logic       rd_hit_chop;
  logic       rd_hit_amp2;
  logic [31:0] rd_word;

  // a write is done once both halves are held and no answer is pending
  // holding each half lets the master offer them in either order
  assign wr_fire     = st.aw_held && st.w_held && !st.bvalid;
  assign wr_hit_chop = (st.aw_addr[7:2] == CHOP_OFF[7:2]);
  assign wr_hit_amp2 = (st.aw_addr[7:2] == AMP2_OFF[7:2]);

  // byte lanes: bits 14:8 ride lane one, the rest lane zero
  // lanes two and three hold only reserved bits, so they are ignored
  assign we_chop    = wr_fire && wr_hit_chop && st.w_strb[0];
  assign we_amp2_b0 = wr_fire && wr_hit_amp2 && st.w_strb[0];
  assign we_amp2_b1 = wr_fire && wr_hit_amp2 && st.w_strb[1];

  // one flop group per field keeps each reset value beside its bits
  // chop disable, resets to one
  afc_field #(
    .W   (1),
    .RST (CHOP_RST[`AFC_CHOP_BIT])
  ) u_chop (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_chop),
    .wdata_in (st.w_data[`AFC_CHOP_BIT]),
    .q_out    (chop_q)
  );

  // sink current boost
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_SINK_BIT])
  ) u_sink (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b1),
    .wdata_in (st.w_data[`AFC_SINK_BIT]),
    .q_out    (sink_q)
  );

  // spare storage inside the overlapped range
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_SPARE13_BIT])
  ) u_sp13 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b1),
    .wdata_in (st.w_data[`AFC_SPARE13_BIT]),
    .q_out    (spare13_q)
  );

  // transimpedance bias source select
  afc_field #(
    .W   (2),
    .RST (AMP2_RST[`AFC_BIAS_MSB:`AFC_BIAS_LSB])
  ) u_bias (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b1),
    .wdata_in (st.w_data[`AFC_BIAS_MSB:`AFC_BIAS_LSB]),
    .q_out    (bias_q)
  );

  // transimpedance resistor code
  afc_field #(
    .W   (3),
    .RST (AMP2_RST[`AFC_RES_MSB:`AFC_RES_LSB])
  ) u_res (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b1),
    .wdata_in (st.w_data[`AFC_RES_MSB:`AFC_RES_LSB]),
    .q_out    (res_q)
  );

  // amplifier gain code
  afc_field #(
    .W   (3),
    .RST (AMP2_RST[`AFC_GAIN_MSB:`AFC_GAIN_LSB])
  ) u_gain (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_GAIN_MSB:`AFC_GAIN_LSB]),
    .q_out    (gain_q)
  );

  // spare storage, resets to one
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_SPARE4_BIT])
  ) u_sp4 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_SPARE4_BIT]),
    .q_out    (spare4_q)
  );

  // external filter capacitor bypass
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_CAP_BIT])
  ) u_cap (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_CAP_BIT]),
    .q_out    (cap_q)
  );

  // dc or ac coupling
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_COUPLING_BIT])
  ) u_coup (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_COUPLING_BIT]),
    .q_out    (coup_q)
  );

  // gain or transimpedance function
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_FUNC_BIT])
  ) u_func (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_FUNC_BIT]),
    .q_out    (func_q)
  );

  // core power down, resets to one
  afc_field #(
    .W   (1),
    .RST (AMP2_RST[`AFC_PD_BIT])
  ) u_pd (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wr_en_in (we_amp2_b0),
    .wdata_in (st.w_data[`AFC_PD_BIT]),
    .q_out    (pd_q)
  );

  // read decode straight from the address channel
  // decoding before the take saves a cycle, but a write that lands
  // on the same edge as the take is read back with its old value
  assign rd_hit_chop = (s_axi_araddr_in[7:2] == CHOP_OFF[7:2]);
  assign rd_hit_amp2 = (s_axi_araddr_in[7:2] == AMP2_OFF[7:2]);

  // read word assembly; unused bits are constant zero
  // bits 13 and 4 read back as stored, like any other field
  always_comb begin
    rd_word = 32'h00000000;
    if (rd_hit_chop) begin
      rd_word[`AFC_CHOP_BIT] = chop_q;
    end else if (rd_hit_amp2) begin
      rd_word[`AFC_SINK_BIT]               = sink_q;
      rd_word[`AFC_SPARE13_BIT]            = spare13_q;
      rd_word[`AFC_BIAS_MSB:`AFC_BIAS_LSB] = bias_q;
      rd_word[`AFC_RES_MSB:`AFC_RES_LSB]   = res_q;
      rd_word[`AFC_GAIN_MSB:`AFC_GAIN_LSB] = gain_q;
      rd_word[`AFC_SPARE4_BIT]             = spare4_q;
      rd_word[`AFC_CAP_BIT]                = cap_q;
      rd_word[`AFC_COUPLING_BIT]           = coup_q;
      rd_word[`AFC_FUNC_BIT]               = func_q;
      rd_word[`AFC_PD_BIT]                 = pd_q;
    end
  end

  // bus handshakes and derived outputs
  // a slow bready stalls only the write side, reads keep going
  always_comb begin
    next_st = st;
    // address and data are taken independently, in either order
    if (s_axi_awvalid_in && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    // unmapped writes change nothing but are still answered
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (wr_hit_chop || wr_hit_amp2) ?
                        `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    // one write in flight: no new halves until the answer is gone
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;
    // read answers on the same edge that takes the address
    if (s_axi_arvalid_in && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = (rd_hit_chop || rd_hit_amp2) ?
                       `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
    // derived outputs trail the fields by one edge
    // the extra flop keeps every output on a register, at one edge of lag
    next_st.bias_onehot = 4'(4'h1 << bias_q);
    next_st.sample_mult = chop_q ? `AFC_SAMPLE_MULT_NORMAL
                                 : `AFC_SAMPLE_MULT_CHOP;
    // undefined codes are stored as written, only flagged
    next_st.code_invalid = (res_q > `AFC_RES_CODE_MAX) ||
                           (gain_q > `AFC_GAIN_CODE_MAX);
  end

  // state register
  // derived outputs reset to what the field reset values imply
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st             <= '0;
      st.bias_onehot <= 4'h1;
      st.sample_mult <= `AFC_SAMPLE_MULT_NORMAL;
    end else begin
      st <= next_st;
    end
  end

  // bus outputs
  assign s_axi_awready_out = st.awready;
  assign s_axi_wready_out  = st.wready;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_arready_out = st.arready;
  assign s_axi_rvalid_out  = st.rvalid;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;

  // analog-facing outputs, all from field or state flops
  // field outputs follow a write on the edge that raises bvalid, derived outputs one edge later
  assign chop_disable_out       = chop_q;
  assign sample_time_mult_out   = st.sample_mult;
  assign bias_source_onehot_out = st.bias_onehot;
  assign code_invalid_out       = st.code_invalid;
  assign amp2_cfg_out.sink_boost                   = sink_q;
  assign amp2_cfg_out.transimpedance_bias_select   = bias_q;
  assign amp2_cfg_out.transimpedance_resistor_code = res_q;
  assign amp2_cfg_out.amp_gain_code                = gain_q;
  assign amp2_cfg_out.filter_cap_bypass            = cap_q;
  assign amp2_cfg_out.coupling_select              = coup_q;
  assign amp2_cfg_out.tia_mode_select              = func_q;
  assign amp2_cfg_out.amp_core_power_down          = pd_q;
endmodule

// *** afc_defs.svh ***
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH

// bus geometry
`define AFC_ADDR_W          8
`define AFC_DATA_W          32
`define AFC_STRB_W          4

// register byte offsets
`define AFC_CHOP_OFFSET     8'h74
`define AFC_AMP2_OFFSET     8'hA0

// register reset values
`define AFC_CHOP_RESET      32'h00000001
`define AFC_AMP2_RESET      32'h00000019

// chop register field
`define AFC_CHOP_BIT        0

// amp2 control fields
`define AFC_SINK_BIT        14
`define AFC_SPARE13_BIT     13
`define AFC_BIAS_MSB        12
`define AFC_BIAS_LSB        11
`define AFC_RES_MSB         10
`define AFC_RES_LSB         8
`define AFC_GAIN_MSB        7
`define AFC_GAIN_LSB        5
`define AFC_SPARE4_BIT      4
`define AFC_CAP_BIT         3
`define AFC_COUPLING_BIT    2
`define AFC_FUNC_BIT        1
`define AFC_PD_BIT          0

// highest defined codes
`define AFC_RES_CODE_MAX    3'h6
`define AFC_GAIN_CODE_MAX   3'h5

// converter sample time multipliers
`define AFC_SAMPLE_MULT_CHOP   2'h2
`define AFC_SAMPLE_MULT_NORMAL 2'h1

// bus responses
`define AFC_RESP_OKAY       2'h0
`define AFC_RESP_SLVERR     2'h2

`endif

// *** afc_pkg.sv ***
package afc_pkg;
  `include "afc_defs.svh"

  // amp2 configuration as seen by the analog side
  typedef struct packed {
    logic       sink_boost;
    logic [1:0] transimpedance_bias_select;
    logic [2:0] transimpedance_resistor_code;
    logic [2:0] amp_gain_code;
    logic       filter_cap_bypass;
    logic       coupling_select;
    logic       tia_mode_select;
    logic       amp_core_power_down;
  } afc_amp2_cfg_t;

  // all state of the top module
  typedef struct packed {
    logic                   awready;
    logic                   aw_held;
    logic [`AFC_ADDR_W-1:0] aw_addr;
    logic                   wready;
    logic                   w_held;
    logic [`AFC_DATA_W-1:0] w_data;
    logic [`AFC_STRB_W-1:0] w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [`AFC_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
    logic [3:0]             bias_onehot;
    logic [1:0]             sample_mult;
    logic                   code_invalid;
  } afc_state_t;
endpackage

// *** afc_field.sv ***
`timescale 1ns/1ps
// one software-writable field with its own reset value
module afc_field #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // write side
  input  wire logic         wr_en_in,
  input  wire logic [W-1:0] wdata_in,
  // stored value
  output logic [W-1:0]      q_out
);
  typedef struct packed {
    logic [W-1:0] q;
  } afc_field_state_t;

  afc_field_state_t st;
  afc_field_state_t next_st;

  // load on write, hold otherwise
  always_comb begin
    next_st = st;
    if (wr_en_in) begin
      next_st.q = wdata_in;
    end
  end

  // reset loads the constant only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= afc_field_state_t'(RST);
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.q;
endmodule

// *** afc_regs_chk.sv ***
`timescale 1ns/1ps
`include "afc_defs.svh"
// bus and analog-side checks, bound onto afc_regs
module afc_regs_chk (
  // clock and reset
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  // register bus
  input wire logic                   s_axi_awready_out,
  input wire logic                   s_axi_bvalid_out,
  input wire logic [1:0]             s_axi_bresp_out,
  input wire logic                   s_axi_bready_in,
  input wire logic                   s_axi_arvalid_in,
  input wire logic [7:0]             s_axi_araddr_in,
  input wire logic                   s_axi_arready_out,
  input wire logic                   s_axi_rvalid_out,
  input wire logic [31:0]            s_axi_rdata_out,
  input wire logic [1:0]             s_axi_rresp_out,
  input wire logic                   s_axi_rready_in,
  // analog side
  input wire logic                   chop_disable_out,
  input wire logic [1:0]             sample_time_mult_out,
  input wire afc_pkg::afc_amp2_cfg_t amp2_cfg_out,
  input wire logic [3:0]             bias_source_onehot_out,
  input wire logic                   code_invalid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // decoded read requests taken this edge
  wire logic ar_go = s_axi_arvalid_in && s_axi_arready_out;
  wire logic [7:0] ar_a = {s_axi_araddr_in[7:2], 2'h0};
  wire logic rd_chop = ar_go && ar_a == `AFC_CHOP_OFFSET;
  wire logic rd_amp2 = ar_go && ar_a == `AFC_AMP2_OFFSET;
  wire logic rd_bad = ar_go && !rd_chop && !rd_amp2;
  wire logic [31:0] r = s_axi_rdata_out;

  property p_rd_chop;
    rd_chop |=> s_axi_rvalid_out && r == {31'h0, $past(chop_disable_out)};
  endproperty
  a_rd_chop: assert property (p_rd_chop)
    else $error("chop register read mismatch");
  // bits 13 and 4 are not visible at the ports, so they are skipped here
  property p_rd_amp2;
    rd_amp2 |=> {r[31:14], r[12:5], r[3:0]} == {17'h0, $past(amp2_cfg_out)};
  endproperty
  a_rd_amp2: assert property (p_rd_amp2)
    else $error("amp2 register read mismatch");
  property p_rd_bad;
    rd_bad |=> s_axi_rresp_out == `AFC_RESP_SLVERR && r == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_mult;
    sample_time_mult_out == ($past(chop_disable_out) ? 2'h1 : 2'h2);
  endproperty
  a_mult: assert property (p_mult)
    else $error("sample time multiplier wrong");
  property p_onehot;
    bias_source_onehot_out ==
      4'h1 << $past(amp2_cfg_out.transimpedance_bias_select);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("bias source select wrong");
  property p_code;
    code_invalid_out ==
      ($past(amp2_cfg_out.transimpedance_resistor_code) == 3'h7 ||
       $past(amp2_cfg_out.amp_gain_code) > `AFC_GAIN_CODE_MAX);
  endproperty
  a_code: assert property (p_code)
    else $error("code flag wrong");
  // fields may only move with an accepted write
  property p_chg;
    $changed(chop_disable_out) || $changed(amp2_cfg_out) |->
      $rose(s_axi_bvalid_out) && s_axi_bresp_out == `AFC_RESP_OKAY;
  endproperty
  a_chg: assert property (p_chg)
    else $error("field changed without a write");
  property p_bhold;
    s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out) && !s_axi_awready_out;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(r) && !s_axi_arready_out;
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  c_rd_bad: cover property (rd_bad ##1 s_axi_rvalid_out);
  c_chop_on: cover property ($fell(chop_disable_out));
  c_code: cover property ($rose(code_invalid_out));
  c_bwait: cover property (s_axi_bvalid_out && !s_axi_bready_in);
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "afc_defs.svh"
module tb_top;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [1:0]  r;
    logic [31:0] q;
  } afc_tb_row_t;
  // bus drive and observed outputs
  logic                   clk_in, rst_n_in, awvalid, wvalid, bready;
  logic                   arvalid, rready, awready, wready, bvalid;
  logic                   arready, rvalid, chop, code_inv;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata, v;
  logic [3:0]             wstrb, onehot;
  logic [1:0]             bresp, rresp, mult;
  afc_pkg::afc_amp2_cfg_t cfg;
  int                     bad_count, comparisons, cycles, lag;
  localparam logic [1:0]  ok = `AFC_RESP_OKAY;
  localparam logic [1:0]  er = `AFC_RESP_SLVERR;
  // address, data, strobe, response, read-back
  afc_tb_row_t rows [8] = '{
    '{8'hA0, 32'h0, 4'hF, ok, 32'h0},
    '{8'hA0, 32'hFFFFFFFF, 4'hF, ok, 32'h7FFF},
    '{8'hA0, 32'h0, 4'h2, ok, 32'hFF},
    '{8'hA0, 32'hFFFFFFFF, 4'h0, ok, 32'hFF},
    '{8'h74, 32'hFFFFFFFE, 4'hF, ok, 32'h0},
    '{8'h74, 32'hFFFFFFFF, 4'h1, ok, 32'h1},
    '{8'h10, 32'hFFFFFFFF, 4'hF, er, 32'h0},
    '{8'h77, 32'h0, 4'hF, ok, 32'h0}};

  afc_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awaddr_in(awaddr),
    .s_axi_awready_out(awready), .s_axi_wvalid_in(wvalid),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wready_out(wready), .s_axi_bvalid_out(bvalid),
    .s_axi_bresp_out(bresp), .s_axi_bready_in(bready),
    .s_axi_arvalid_in(arvalid), .s_axi_araddr_in(araddr),
    .s_axi_arready_out(arready), .s_axi_rvalid_out(rvalid),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rready_in(rready), .chop_disable_out(chop),
    .sample_time_mult_out(mult), .amp2_cfg_out(cfg),
    .bias_source_onehot_out(onehot), .code_invalid_out(code_inv));

  function automatic afc_pkg::afc_amp2_cfg_t cfg_of(input logic [31:0] x);
    return {x[14], x[12:5], x[3:0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // write: offer address and data together, release each when taken;
  // a nonzero lag raises bready late so that bvalid must stand
  task automatic acc(input afc_tb_row_t x);
    int n;
    n = 0;
    @(posedge clk_in);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= x.a;
    wdata <= x.d;
    wstrb <= x.s;
    bready <= (lag == 0);
    do begin
      @(posedge clk_in);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (!bready && n >= lag) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", 32'(x.r), 32'(bresp));
    rd(x.a, x.r, x.q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r,
                    input logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= (lag == 0);
    do begin
      @(posedge clk_in);
      n++;
      if (arready) arvalid <= 1'b0;
      if (!rready && n >= lag) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk("rresp", 32'(r), 32'(rresp));
    chk("rdata", q, rdata);
  endtask

  task automatic reset_checks();
    rd(`AFC_CHOP_OFFSET, ok, `AFC_CHOP_RESET);
    rd(`AFC_AMP2_OFFSET, ok, `AFC_AMP2_RESET);
    chk("chop", 32'h1, 32'(chop));
    chk("mult", 32'h1, 32'(mult));
    chk("cfg", 32'(cfg_of(`AFC_AMP2_RESET)), 32'(cfg));
    chk("onehot", 32'h1, 32'(onehot));
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    {rst_n_in, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_checks();
    foreach (rows[i]) begin
      acc(rows[i]);
      if (rows[i].a[7:2] == 6'h1D) begin
        chk("chop", 32'(rows[i].q[0]), 32'(chop));
        chk("mult", rows[i].q[0] ? 32'h1 : 32'h2, 32'(mult));
      end
      if (rows[i].a == `AFC_AMP2_OFFSET)
        chk("cfg", 32'(cfg_of(rows[i].q)), 32'(cfg));
    end
    // every resistor, gain and bias code, undefined ones flagged
    for (int i = 0; i < 8; i++) begin
      v = 32'(i << 8 | i << 5 | (i % 4) << 11);
      acc('{`AFC_AMP2_OFFSET, v, 4'hF, ok, v});
      chk("cfg", 32'(cfg_of(v)), 32'(cfg));
      chk("onehot", 32'h1 << v[12:11], 32'(onehot));
      chk("code flag", 32'(i > 5), 32'(code_inv));
    end
    // slow bready and rready: both answers must stand until taken
    lag = 3;
    acc('{`AFC_AMP2_OFFSET, 32'h4000, 4'hF, ok, 32'h4000});
    lag = 0;
    chk("cfg", 32'(cfg_of(32'h4000)), 32'(cfg));
    // reset in mid-run restores both registers
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_checks();
    end_of_test();
  end
endmodule

bind afc_regs afc_regs_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rready_in(s_axi_rready_in),
  .chop_disable_out(chop_disable_out),
  .sample_time_mult_out(sample_time_mult_out),
  .amp2_cfg_out(amp2_cfg_out),
  .bias_source_onehot_out(bias_source_onehot_out),
  .code_invalid_out(code_invalid_out));
